/* File: rtl/efc_flash_ctrl.sv */
// embedded flash controller: windowed reads, background wordline program, sector erase
module efc_flash_ctrl #(
  parameter int unsigned PROG_CYCLES = efc_pkg::PROG_SYS_CYCLES,
  parameter int unsigned ERASE_CYCLES = efc_pkg::ERASE_SYS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire efc_pkg::efc_rd_t rdReq,
  input wire efc_pkg::efc_req_t appReq,
  input wire efc_pkg::efc_req_t loaderReq,
  input wire logic programDoneNmiEnable,
  input wire logic programDoneClear,
  output logic rdValid,
  output logic [7:0] rdData,
  output logic rdMiss,
  output logic busy,
  output logic reqRefused,
  output logic programDoneFlag,
  output logic programDoneNmi
);
  // -----------------------------------------------------------------
  // state and storage
  // -----------------------------------------------------------------
  typedef enum {ST_IDLE, ST_PROG, ST_ERASE} efc_state_t;
  efc_state_t state_reg, state_next;
  logic [efc_pkg::CNT_W-1:0] cnt_reg, cnt_next; // remaining op cycles
  logic [efc_pkg::WL_IDX_W-1:0] wl_reg, wl_next;
  logic [efc_pkg::SECTORS-1:0] mask_reg, mask_next;
  logic [efc_pkg::WORDLINE_BYTES*8-1:0] buf_reg, buf_next; // latched program data
  logic done_reg, done_next;
  logic nmi_reg, nmi_next;
  logic refuse_reg, refuse_next;
  logic rdv_reg, rdv_next;
  logic miss_reg, miss_next;
  logic [7:0] rdd_reg, rdd_next;
  logic rdPend_reg, rdPend_next; // read accepted, answered next cycle
  logic [efc_pkg::ADDR_W-1:0] rdAddr_reg, rdAddr_next;
  logic [efc_pkg::CODE_W-1:0] mem [efc_pkg::ARRAY_BYTES]; // array with check bits
  logic [1:0] pcount [efc_pkg::WORDLINES]; // program count per wordline since erase
  efc_pkg::efc_req_t req;
  logic [efc_pkg::CODE_W-1:0] rdCode;
  logic [7:0] rdCorr;
  logic [efc_pkg::CODE_W-1:0] encCode [efc_pkg::WORDLINE_BYTES];
  logic finish;

  // window decode shared by reads and program targets
  function automatic logic inWindow(input logic [15:0] a);
    return (a <= efc_pkg::LOW_END) || (a >= efc_pkg::HIGH_BASE && a <= efc_pkg::HIGH_END);
  endfunction
  function automatic logic [efc_pkg::ADDR_W-1:0] physAddr(input logic [15:0] a);
    return a[efc_pkg::ADDR_W-1:0];
  endfunction

  // application wins over loader when both ask together
  assign req = appReq.valid ? appReq : loaderReq;

  // -----------------------------------------------------------------
  // check-bit encoders for a whole wordline, one shared decoder
  // -----------------------------------------------------------------
  for (genvar g = 0; g < efc_pkg::WORDLINE_BYTES; g++) begin : g_enc
    efc_ecc u_enc (
      .dataIn(buf_reg[g*8 +: 8]),
      .codeIn('0),
      .codeOut(encCode[g]),
      .dataOut()
    );
  end
  efc_ecc u_dec (
    .dataIn(8'h00),
    .codeIn(rdCode),
    .codeOut(),
    .dataOut(rdCorr)
  );
  assign rdCode = mem[rdAddr_reg];

  // -----------------------------------------------------------------
  // sequencer next state
  // -----------------------------------------------------------------
  assign finish = (state_reg != ST_IDLE) && (cnt_reg == '0);
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    wl_next = wl_reg;
    mask_next = mask_reg;
    buf_next = buf_reg;
    refuse_next = 1'b0;
    // set wins over a clear in the same cycle
    done_next = programDoneClear ? 1'b0 : done_reg;
    nmi_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (req.valid && req.cmd == efc_pkg::EFC_CMD_PROG) begin
          // misaligned, outside, or third program is refused
          if (!inWindow(req.addr) || req.addr[efc_pkg::WL_OFS_W-1:0] != '0 ||
              pcount[req.addr[efc_pkg::ADDR_W-1:efc_pkg::WL_OFS_W]] >= 2'(efc_pkg::PROG_LIMIT)) begin
            refuse_next = 1'b1;
          end else begin
            state_next = ST_PROG;
            wl_next = req.addr[efc_pkg::ADDR_W-1:efc_pkg::WL_OFS_W];
            buf_next = req.data;
            cnt_next = efc_pkg::CNT_W'(PROG_CYCLES - 1);
          end
        end else if (req.valid && req.cmd == efc_pkg::EFC_CMD_ERASE) begin
          if (req.sectMask == '0) begin
            refuse_next = 1'b1;
          end else begin
            state_next = ST_ERASE;
            mask_next = req.sectMask;
            cnt_next = efc_pkg::CNT_W'(ERASE_CYCLES - 1);
          end
        end
      end
      ST_PROG: begin
        if (req.valid) begin
          refuse_next = 1'b1; // busy: nothing else is taken
        end
        if (cnt_reg == '0) begin
          state_next = ST_IDLE;
          done_next = 1'b1;
          nmi_next = programDoneNmiEnable;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      ST_ERASE: begin
        if (req.valid && req.cmd == efc_pkg::EFC_CMD_ABORT) begin
          state_next = ST_IDLE;
          cnt_next = '0;
        end else begin
          // a request on the last erase edge is refused, not dropped silently
          if (req.valid) begin
            refuse_next = 1'b1;
          end
          if (cnt_reg == '0) begin
            state_next = ST_IDLE;
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // array update: program writes ones, erase clears whole sectors
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (clkEn && finish && state_reg == ST_PROG) begin
      for (int b = 0; b < efc_pkg::WORDLINE_BYTES; b++) begin
        mem[{wl_reg, 5'(b)}] <= mem[{wl_reg, 5'(b)}] | encCode[b];
      end
      pcount[wl_reg] <= pcount[wl_reg] + 2'd1;
    end else if (clkEn && finish && state_reg == ST_ERASE) begin
      for (int a = 0; a < efc_pkg::ARRAY_BYTES; a++) begin
        if (mask_reg[a >> efc_pkg::SECT_SHIFT]) begin
          mem[a] <= {efc_pkg::CODE_W{1'b0}};
        end
      end
      for (int w = 0; w < efc_pkg::WORDLINES; w++) begin
        if (mask_reg[w >> (efc_pkg::SECT_SHIFT - efc_pkg::WL_OFS_W)]) begin
          pcount[w] <= 2'd0;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // read path: accept, then answer with corrected byte
  // -----------------------------------------------------------------
  always_comb begin
    rdPend_next = 1'b0;
    rdAddr_next = rdAddr_reg;
    rdv_next = 1'b0;
    miss_next = 1'b0;
    rdd_next = rdd_reg;
    if (rdPend_reg) begin
      rdv_next = 1'b1;
      rdd_next = rdCorr;
    end else if (rdReq.valid) begin
      if (!inWindow(rdReq.addr) || state_reg != ST_IDLE) begin
        miss_next = 1'b1;
      end else begin
        rdPend_next = 1'b1;
        rdAddr_next = physAddr(rdReq.addr);
      end
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      wl_reg <= '0;
      mask_reg <= '0;
      buf_reg <= '0;
      done_reg <= 1'b0;
      nmi_reg <= 1'b0;
      refuse_reg <= 1'b0;
      rdv_reg <= 1'b0;
      miss_reg <= 1'b0;
      rdd_reg <= 8'h00;
      rdPend_reg <= 1'b0;
      rdAddr_reg <= '0;
    end else if (clkEn) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      wl_reg <= wl_next;
      mask_reg <= mask_next;
      buf_reg <= buf_next;
      done_reg <= done_next;
      nmi_reg <= nmi_next;
      refuse_reg <= refuse_next;
      rdv_reg <= rdv_next;
      miss_reg <= miss_next;
      rdd_reg <= rdd_next;
      rdPend_reg <= rdPend_next;
      rdAddr_reg <= rdAddr_next;
    end
  end

  // busy mirrors the sequencer state, registered
  logic busy_reg;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
    end else if (clkEn) begin
      busy_reg <= (state_next != ST_IDLE);
    end
  end

  assign rdValid = rdv_reg;
  assign rdData = rdd_reg;
  assign rdMiss = miss_reg;
  assign busy = busy_reg;
  assign reqRefused = refuse_reg;
  assign programDoneFlag = done_reg;
  assign programDoneNmi = nmi_reg;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  read_answer_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (clkEn && rdReq.valid && !rdPend_reg && !rdv_reg && !miss_reg)
    |=> (miss_reg or (rdPend_reg ##1 (rdv_reg && !miss_reg))))
    else $error("read not answered in time");
  prog_block_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == ST_PROG && clkEn && rdReq.valid && !rdPend_reg) |=> miss_reg)
    else $error("read served while programming");
  prog_len_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == ST_PROG && cnt_reg == '0 && clkEn) |=> (done_reg && state_reg == ST_IDLE))
    else $error("program end missing flag");
  nmi_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    programDoneNmi |-> (programDoneFlag && $past(programDoneNmiEnable)))
    else $error("nmi without enable");
  erase_abort_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == ST_ERASE && clkEn && req.valid && req.cmd == efc_pkg::EFC_CMD_ABORT)
    |=> state_reg == ST_IDLE)
    else $error("abort ignored");
  erase_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == ST_IDLE && state_next == ST_ERASE && clkEn)
    |=> cnt_reg == efc_pkg::CNT_W'(ERASE_CYCLES - 1))
    else $error("erase count wrong");
  prog_align_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == ST_IDLE && clkEn && req.valid && req.cmd == efc_pkg::EFC_CMD_PROG &&
     req.addr[4:0] != 5'h00) |=> (reqRefused && state_reg == ST_IDLE))
    else $error("misaligned program taken");
  third_prog_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == ST_IDLE && clkEn && req.valid && req.cmd == efc_pkg::EFC_CMD_PROG &&
     pcount[req.addr[11:5]] == 2'd2) |=> reqRefused)
    else $error("third program taken");
endmodule // efc_flash_ctrl

/* File: rtl/efc_pkg.sv */
// package for the embedded flash controller: sizes, windows, timing, command carriers
package efc_pkg;
  // -----------------------------------------------------------------
  // array geometry
  // -----------------------------------------------------------------
  localparam int unsigned ARRAY_BYTES = 4096;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned WORDLINE_BYTES = 32;
  localparam int unsigned WL_OFS_W = 5;
  localparam int unsigned WORDLINES = ARRAY_BYTES / WORDLINE_BYTES;
  localparam int unsigned WL_IDX_W = 7;
  localparam int unsigned SECTORS = 8;
  localparam int unsigned SECT_IDX_W = 3;
  localparam int unsigned SECT_SHIFT = 9;
  localparam int unsigned ECC_W = 5;
  localparam int unsigned CODE_W = 13;
  localparam int unsigned PROG_LIMIT = 2;
  localparam logic [7:0] ERASED_BYTE = 8'h00;
  // -----------------------------------------------------------------
  // code-space windows
  // -----------------------------------------------------------------
  localparam logic [15:0] LOW_BASE = 16'h0000;
  localparam logic [15:0] LOW_END = 16'h0FFF;
  localparam logic [15:0] HIGH_BASE = 16'hA000;
  localparam logic [15:0] HIGH_END = 16'hAFFF;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int unsigned READ_CORE_PERIODS = 3;
  localparam int unsigned READ_CYCLES = 2;
  localparam int unsigned PROG_SYS_CYCLES = 209440;
  localparam int unsigned ERASE_SYS_CYCLES = 8175360;
  localparam int unsigned CNT_W = 24;
  // -----------------------------------------------------------------
  // carriers
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {EFC_CMD_PROG, EFC_CMD_ERASE, EFC_CMD_ABORT, EFC_CMD_NONE} efc_cmd_t;
  typedef struct packed {
    logic valid;
    efc_cmd_t cmd;
    logic [15:0] addr;
    logic [SECTORS-1:0] sectMask;
    logic [WORDLINE_BYTES*8-1:0] data;
  } efc_req_t;
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } efc_rd_t;
endpackage

/* File: rtl/efc_ecc.sv */
// single-error-correcting check code for one stored byte
module efc_ecc (
  input wire logic [7:0] dataIn,
  input wire logic [efc_pkg::CODE_W-1:0] codeIn,
  output logic [efc_pkg::CODE_W-1:0] codeOut,
  output logic [7:0] dataOut
);
  // -----------------------------------------------------------------
  // hamming(12,8) plus overall parity
  // -----------------------------------------------------------------
  function automatic logic [11:0] spread(input logic [7:0] d);
    logic [11:0] c;
    c = 12'h000;
    c[2] = d[0]; c[4] = d[1]; c[5] = d[2]; c[6] = d[3];
    c[8] = d[4]; c[9] = d[5]; c[10] = d[6]; c[11] = d[7];
    return c;
  endfunction
  function automatic logic [3:0] syn(input logic [11:0] c);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 0; i < 12; i++) begin
      if (c[i]) begin
        s = s ^ 4'(i + 1);
      end
    end
    return s;
  endfunction
  // encoder: fill parity positions so syndrome is zero
  always_comb begin
    logic [11:0] c;
    logic [3:0] s;
    c = spread(dataIn);
    s = syn(c);
    c[0] = s[0]; c[1] = s[1]; c[3] = s[2]; c[7] = s[3];
    codeOut = {^c, c};
  end
  // decoder: flip the one bit the syndrome names
  always_comb begin
    logic [11:0] c;
    logic [3:0] s;
    c = codeIn[11:0];
    s = syn(c);
    if (s != 4'h0 && s <= 4'd12) begin
      c[s - 4'd1] = ~c[s - 4'd1];
    end
    dataOut = {c[11], c[10], c[9], c[8], c[6], c[5], c[4], c[2]};
  end
endmodule // efc_ecc

/* File: tb/efc_core_model.sv */
// processor core model: issues program, erase and abort requests on either source port
module efc_core_model (
  input wire logic sys_clk,
  output efc_pkg::efc_req_t appReq,
  output efc_pkg::efc_req_t loaderReq
);
  timeunit 1ns;
  timeprecision 100ps;
  // -----------------------------------------------------------------
  // idle request lines
  // -----------------------------------------------------------------
  initial begin
    appReq = '0;
    loaderReq = '0;
  end
  // -----------------------------------------------------------------
  // one request: driven just after an edge, held through the taking edge
  // -----------------------------------------------------------------
  task automatic send(input logic fromLoader, input efc_pkg::efc_cmd_t cmd,
      input logic [15:0] addr, input logic [efc_pkg::SECTORS-1:0] mask,
      input logic [efc_pkg::WORDLINE_BYTES*8-1:0] data);
    efc_pkg::efc_req_t req;
    req = '{valid: 1'b1, cmd: cmd, addr: addr, sectMask: mask, data: data};
    @(posedge sys_clk);
    #1;
    // loader and application share the controller
    if (fromLoader)
      loaderReq = req;
    else
      appReq = req;
    @(posedge sys_clk);
    #1;
    // released fields carry junk so a stale request never looks valid data
    req = ~req;
    req.valid = 1'b0;
    if (fromLoader)
      loaderReq = req;
    else
      appReq = req;
  endtask
endmodule // efc_core_model

/* File: tb/efc_flash_ctrl_tb.sv */
// self-checking bench for the embedded flash controller
module efc_flash_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // -----------------------------------------------------------------
  // constants and signals
  // -----------------------------------------------------------------
  localparam int PCYC = 20; // shortened program time keeps the run short
  localparam int ECYC = 40; // shortened erase time
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] exp;
    logic miss;
  } efc_row_t;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic clkEn = 1'b1; // low only in the freeze scenario
  efc_pkg::efc_rd_t rdReq = '0;
  efc_pkg::efc_req_t appReq;
  efc_pkg::efc_req_t loaderReq;
  logic nmiEnable = 1'b0;
  logic doneClear = 1'b0;
  logic rdValid, rdMiss, busy, reqRefused, programDoneFlag, programDoneNmi;
  logic [7:0] rdData;
  int miscompares = 0;
  int testsRun = 0;
  longint tTake; // time just after the last taking edge
  longint tProg;
  logic [255:0] wl; // wordline image handed to the core model
  efc_row_t rows [11];
  // -----------------------------------------------------------------
  // design and far side
  // -----------------------------------------------------------------
  efc_flash_ctrl #(.PROG_CYCLES(PCYC), .ERASE_CYCLES(ECYC)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn), .rdReq(rdReq),
    .appReq(appReq), .loaderReq(loaderReq), .programDoneNmiEnable(nmiEnable),
    .programDoneClear(doneClear), .rdValid(rdValid), .rdData(rdData), .rdMiss(rdMiss),
    .busy(busy), .reqRefused(reqRefused), .programDoneFlag(programDoneFlag),
    .programDoneNmi(programDoneNmi));
  efc_core_model core (.sys_clk(sys_clk), .appReq(appReq), .loaderReq(loaderReq));
  // clock: 100 ns period
  always #50 sys_clk = ~sys_clk;
  // -----------------------------------------------------------------
  // reporting
  // -----------------------------------------------------------------
  task automatic close_out();
    if (miscompares == 0 && testsRun > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    testsRun++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // a wait that ran out: counted, then straight to the verdict
  task automatic timeout();
    miscompares++;
    $display("BAD %0t wait ran out", $time);
    close_out();
  endtask
  // -----------------------------------------------------------------
  // transactions
  // -----------------------------------------------------------------
  task automatic go(input logic ld, input efc_pkg::efc_cmd_t c, input logic [15:0] a,
      input logic [7:0] m, input logic [255:0] d);
    core.send(ld, c, a, m, d);
    tTake = $time;
  endtask
  // byte read; a refusal shows right after the taking edge, data one edge later
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic miss);
    int n;
    n = 0;
    @(posedge sys_clk);
    #1;
    rdReq = '{valid: 1'b1, addr: a};
    @(posedge sys_clk);
    #1;
    rdReq = '{valid: 1'b0, addr: ~a};
    while (n < 4 && rdValid !== 1'b1 && rdMiss !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 4)
      timeout();
    chk(rdMiss === miss, "read refusal");
    chk(n == (miss ? 0 : 1), "read latency");
    if (!miss)
      chk(rdData === exp, "read data");
  endtask
  // refusal pulse may show right after the take or one edge later
  task automatic refused(input logic expBusy);
    logic seen;
    seen = reqRefused;
    @(posedge sys_clk);
    #1;
    seen = seen | reqRefused;
    chk(seen === 1'b1 && busy === expBusy, "request not refused");
  endtask
  // background operation length, measured from its taking edge
  task automatic wait_op(input longint t0, input logic prog, input int exp, input logic nmi);
    int i;
    for (i = 0; i < 200 && (prog ? programDoneFlag !== 1'b1 : busy !== 1'b0); i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (i == 200)
      timeout();
    chk(($time - t0) / 100 == exp, "operation length");
    chk(busy === 1'b0 && programDoneFlag === prog, "end state");
    chk(programDoneNmi === nmi, "completion interrupt");
  endtask
  task automatic clear_done();
    @(posedge sys_clk);
    #1;
    doneClear = 1'b1;
    @(posedge sys_clk);
    #1;
    doneClear = 1'b0;
    chk(programDoneFlag === 1'b0, "flag not cleared");
  endtask
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    rows = '{'{16'h0020, 8'h81, 1'b0}, '{16'hA020, 8'h81, 1'b0}, '{16'h002F, 8'h90, 1'b0},
      '{16'hA02F, 8'h90, 1'b0}, '{16'h0030, 8'h00, 1'b0}, '{16'h0FFF, 8'h00, 1'b0},
      '{16'hAFFF, 8'h00, 1'b0}, '{16'h1000, 8'h00, 1'b1}, '{16'h9FFF, 8'h00, 1'b1},
      '{16'hB000, 8'h00, 1'b1}, '{16'hFFFF, 8'h00, 1'b1}};
    repeat (5) @(posedge sys_clk);
    #1;
    chk(busy === 1'b0 && rdValid === 1'b0 && programDoneFlag === 1'b0, "reset outputs");
    chk(rdMiss === 1'b0 && reqRefused === 1'b0 && programDoneNmi === 1'b0, "reset pulses");
    nrst = 1'b1;
    // unknown array contents: erase every sector in one go
    go(1'b0, efc_pkg::EFC_CMD_ERASE, 16'h0000, 8'hFF, '0);
    rd(16'h0100, 8'h00, 1'b1);
    wait_op(tTake, 1'b0, ECYC, 1'b0);
    // first program via the loader, bytes 16..31 left at zero
    for (int b = 0; b < 32; b++)
      wl[8*b +: 8] = (b < 16) ? 8'h81 + 8'(b) : 8'h00;
    nmiEnable = 1'b1;
    go(1'b1, efc_pkg::EFC_CMD_PROG, 16'h0020, 8'h00, wl);
    tProg = tTake;
    go(1'b0, efc_pkg::EFC_CMD_PROG, 16'h0040, 8'h00, wl);
    refused(1'b1);
    rd(16'h0020, 8'h00, 1'b1);
    wait_op(tProg, 1'b1, PCYC, 1'b1);
    clear_done();
    foreach (rows[i])
      rd(rows[i].addr, rows[i].exp, rows[i].miss);
    // second program: zeros over bytes already written
    for (int b = 0; b < 32; b++)
      wl[8*b +: 8] = (b < 16) ? 8'h00 : 8'h3C;
    nmiEnable = 1'b0;
    go(1'b0, efc_pkg::EFC_CMD_PROG, 16'hA020, 8'h00, wl);
    // three frozen edges stretch the program by three cycles
    @(posedge sys_clk);
    #1;
    clkEn = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(busy === 1'b1 && programDoneFlag === 1'b0, "frozen state");
    clkEn = 1'b1;
    wait_op(tTake, 1'b1, PCYC + 3, 1'b0);
    clear_done();
    rd(16'h0030, 8'h3C, 1'b0);
    rd(16'h0020, 8'h81, 1'b0);
    go(1'b0, efc_pkg::EFC_CMD_PROG, 16'h0020, 8'h00, wl);
    refused(1'b0);
    // an all-zero image is taken but leaves the wordline erased
    go(1'b0, efc_pkg::EFC_CMD_PROG, 16'h0060, 8'h00, '0);
    wait_op(tTake, 1'b1, PCYC, 1'b0);
    clear_done();
    rd(16'h0060, 8'h00, 1'b0);
    go(1'b1, efc_pkg::EFC_CMD_PROG, 16'h0041, 8'h00, wl);
    refused(1'b0);
    go(1'b0, efc_pkg::EFC_CMD_ERASE, 16'h0000, 8'h00, '0);
    refused(1'b0);
    // erase aborted part way leaves the array readable and untouched
    go(1'b0, efc_pkg::EFC_CMD_ERASE, 16'h0000, 8'h01, '0);
    repeat (5) @(posedge sys_clk);
    go(1'b1, efc_pkg::EFC_CMD_ABORT, 16'h0000, 8'h00, '0);
    @(posedge sys_clk);
    #1;
    chk(busy === 1'b0, "abort left busy");
    rd(16'h0020, 8'h81, 1'b0);
    // full erase of sector 0 clears both halves of wordline 1
    go(1'b0, efc_pkg::EFC_CMD_ERASE, 16'h0000, 8'h01, '0);
    wait_op(tTake, 1'b0, ECYC, 1'b0);
    rd(16'h0030, 8'h00, 1'b0);
    rd(16'hA020, 8'h00, 1'b0);
    close_out();
  end
endmodule // efc_flash_ctrl_tb
